// ==== ir_remote_pkg.sv ====
// package for the infrared remote unit: register map, fields, reset values
// assumes a 32-bit avalon-mm slave with byte addresses, one word per register
package ir_remote_pkg;

	// register byte offsets
	localparam logic [4:0] CFG_OFS  = 5'h00;
	localparam logic [4:0] CAR_OFS  = 5'h04;
	localparam logic [4:0] LCNT_OFS = 5'h08;
	localparam logic [4:0] STAT_OFS = 5'h0c;
	localparam logic [4:0] MASK_OFS = 5'h10;

	// configuration fields
	localparam int EN_POS    = 0;  // unit_enable
	localparam int DIR_POS   = 1;  // direction_select, 1 = receive
	localparam int CDIV_POS  = 4;  // carrier_clock_divsel [3:0]
	localparam int LDIV_POS  = 8;  // length_clock_divsel [3:0]
	// carrier fields
	localparam int HIGH_POS  = 0;  // carrier_high_len [5:0]
	localparam int LOW_POS   = 8;  // carrier_low_len [5:0]
	// length counter fields
	localparam int LEVEL_POS = 0;  // pulse_level
	localparam int COUNT_POS = 8;  // pulse_length_count [7:0]
	// status and mask bit positions
	localparam int UNDER_POS = 0;
	localparam int RISE_POS  = 1;
	localparam int FALL_POS  = 2;

	// reset values
	localparam logic [3:0] DIV_RST   = 4'h0;
	localparam logic [5:0] LEN_RST   = 6'h00;
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [2:0] FLAG_RST  = 3'h0;

	// division code with no clock
	localparam logic [3:0] DIV_RESERVED = 4'hf;
	// prescaler width covers the 1/16384 ratio
	localparam int PRE_W = 14;

endpackage

// ==== ir_remote_unit.sv ====
// infrared remote unit: carrier generator, pulse length counter, modulator,
// receive edge detector, avalon-mm register slave and one level interrupt
// assumes one 20 MHz clock i_ref_clk, synchronous active-high reset i_rst
// Overview of operation
// - one receive input pin, one modulated transmit pin
// - carrier clock divided by code, 0xf reserved
// - carrier high/low last length plus one
// - written counter counts down, underflow event, stops
// - counter clock divided by own code
// - rising and falling receive edges raise separate events
// - counter readable at edge for pulse measurement
// - direction bit picks transmit or receive, enable starts
// - transmit pin shows level gated by carrier
// - receive edge needs two equal carrier samples
// - three flags, own enables, shared interrupt, write-one clear
module ir_remote_unit
	import ir_remote_pkg::*;
(
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	// avalon-mm slave
	input  wire logic [4:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	// infrared pins
	input  wire logic        i_ir_rx_input,
	output logic             o_ir_tx_output,
	// interrupt
	output logic             o_irq
);

	////////////////////////////////////////////////////////////////////////////
	// functions

	// one-cycle tick of a divided clock taken from the shared prescaler
	function automatic logic div_tick(input logic [PRE_W-1:0] cnt, input logic [3:0] sel);
		logic [PRE_W-1:0] m;
		m = ~({PRE_W{1'b1}} << sel);
		return (sel != DIV_RESERVED) && (&(cnt | ~m));
	endfunction

	// byte-lane merge of a write into an old register value
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] bm;
		bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return (old & ~bm) | (wd & bm);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// state

	logic             unit_enable;           // starts the chosen operation
	logic             direction_select;      // 0 transmit, 1 receive
	logic [3:0]       carrier_clock_divsel;  // carrier clock ratio code
	logic [3:0]       length_clock_divsel;   // counter clock ratio code
	logic [5:0]       carrier_high_len;      // high section minus one
	logic [5:0]       carrier_low_len;       // low section minus one
	logic             pulse_level;           // level to transmit
	logic [7:0]       pulse_length_count;    // down-counter
	logic             count_run;             // counter is counting
	logic [2:0]       flags;                 // sticky event flags
	logic [2:0]       mask;                  // flag enables
	logic [PRE_W-1:0] pre;                   // shared prescaler
	logic             car_phase;             // 1 in high section
	logic [5:0]       car_cnt;               // cycles inside a section
	logic             rx_meta;               // first synchroniser stage
	logic             rx_sync;               // second synchroniser stage
	logic             rx_sample;             // last carrier-clock sample
	logic             rx_level;              // accepted receive level

	logic             next_unit_enable;
	logic             next_direction_select;
	logic [3:0]       next_carrier_clock_divsel;
	logic [3:0]       next_length_clock_divsel;
	logic [5:0]       next_carrier_high_len;
	logic [5:0]       next_carrier_low_len;
	logic             next_pulse_level;
	logic [7:0]       next_pulse_length_count;
	logic             next_count_run;
	logic [2:0]       next_flags;
	logic [2:0]       next_mask;
	logic [PRE_W-1:0] next_pre;
	logic             next_car_phase;
	logic [5:0]       next_car_cnt;
	logic             next_rx_sample;
	logic             next_rx_level;
	logic [31:0]      next_readdata;
	logic             next_waitrequest;
	logic             next_tx;
	logic             next_irq;

	logic             cg_tick;     // carrier clock enable pulse
	logic             lc_tick;     // counter clock enable pulse
	logic             bus_go;      // access completes at this edge
	logic             wr_go;       // write takes effect at this edge
	logic             rise_evt;    // accepted rising edge
	logic             fall_evt;    // accepted falling edge
	logic             under_evt;   // counter reached zero
	logic [31:0]      cfg_word;    // current register images
	logic [31:0]      car_word;
	logic [31:0]      lcnt_word;
	logic [31:0]      wd;          // merged write value

	////////////////////////////////////////////////////////////////////////////
	// receive pin synchroniser, only the second stage is read by logic

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			rx_meta <= 1'b0;
			rx_sync <= 1'b0;
		end else begin
			rx_meta <= i_ir_rx_input;
			rx_sync <= rx_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// next-state logic of the whole unit

	always_comb begin
		// register images for reads and merges
		cfg_word = '0;
		cfg_word[EN_POS] = unit_enable;
		cfg_word[DIR_POS] = direction_select;
		cfg_word[CDIV_POS +: 4] = carrier_clock_divsel;
		cfg_word[LDIV_POS +: 4] = length_clock_divsel;
		car_word = '0;
		car_word[HIGH_POS +: 6] = carrier_high_len;
		car_word[LOW_POS +: 6] = carrier_low_len;
		lcnt_word = '0;
		// receive mode reads the accepted pin level
		lcnt_word[LEVEL_POS] = direction_select ? rx_level : pulse_level;
		lcnt_word[COUNT_POS +: 8] = pulse_length_count;

		// bus handshake: answer one cycle after the request is seen
		bus_go = (i_avs_read || i_avs_write) && !o_avs_waitrequest;
		wr_go = i_avs_write && !o_avs_waitrequest;
		next_waitrequest = !((i_avs_read || i_avs_write) && o_avs_waitrequest);
		next_readdata = o_avs_readdata;
		if (i_avs_read && o_avs_waitrequest) begin
			unique case (i_avs_address)
				CFG_OFS:  next_readdata = cfg_word;
				CAR_OFS:  next_readdata = car_word;
				LCNT_OFS: next_readdata = lcnt_word;
				STAT_OFS: next_readdata = {29'h0000_0000, flags};
				MASK_OFS: next_readdata = {29'h0000_0000, mask};
				default:  next_readdata = 32'h0000_0000;  // unmapped reads zero
			endcase
		end

		// default hold
		next_unit_enable = unit_enable;
		next_direction_select = direction_select;
		next_carrier_clock_divsel = carrier_clock_divsel;
		next_length_clock_divsel = length_clock_divsel;
		next_carrier_high_len = carrier_high_len;
		next_carrier_low_len = carrier_low_len;
		next_pulse_level = pulse_level;
		next_mask = mask;
		wd = 32'h0000_0000;

		// dividers, idle at zero while disabled
		next_pre = unit_enable ? pre + 1'b1 : '0;
		cg_tick = unit_enable && div_tick(pre, carrier_clock_divsel);
		lc_tick = unit_enable && div_tick(pre, length_clock_divsel);

		// carrier generator
		next_car_phase = car_phase;
		next_car_cnt = car_cnt;
		if (!unit_enable) begin
			next_car_phase = 1'b1;
			next_car_cnt = '0;
		end else if (cg_tick) begin
			if (car_cnt == (car_phase ? carrier_high_len : carrier_low_len)) begin
				next_car_phase = !car_phase;
				next_car_cnt = '0;
			end else begin
				next_car_cnt = car_cnt + 1'b1;
			end
		end

		// pulse length counter
		next_pulse_length_count = pulse_length_count;
		next_count_run = count_run;
		under_evt = 1'b0;
		if (unit_enable && count_run && lc_tick) begin
			next_pulse_length_count = pulse_length_count - 1'b1;
			if (pulse_length_count == 8'h01) begin
				next_count_run = 1'b0;
				under_evt = 1'b1;
			end
		end

		// receive edge detector on carrier samples
		next_rx_sample = rx_sample;
		next_rx_level = rx_level;
		rise_evt = 1'b0;
		fall_evt = 1'b0;
		if (!unit_enable || !direction_select) begin
			// track the pin so enabling raises no false edge
			next_rx_sample = rx_sync;
			next_rx_level = rx_sync;
		end else if (cg_tick) begin
			next_rx_sample = rx_sync;
			if (rx_sample == rx_sync && rx_sync != rx_level) begin
				next_rx_level = rx_sync;
				rise_evt = rx_sync;
				fall_evt = !rx_sync;
			end
		end

		// register writes
		next_flags = flags;
		if (wr_go) begin
			unique case (i_avs_address)
				CFG_OFS: begin
					wd = merge(cfg_word, i_avs_writedata, i_avs_byteenable);
					next_unit_enable = wd[EN_POS];
					next_direction_select = wd[DIR_POS];
					next_carrier_clock_divsel = wd[CDIV_POS +: 4];
					next_length_clock_divsel = wd[LDIV_POS +: 4];
				end
				CAR_OFS: begin
					wd = merge(car_word, i_avs_writedata, i_avs_byteenable);
					next_carrier_high_len = wd[HIGH_POS +: 6];
					next_carrier_low_len = wd[LOW_POS +: 6];
				end
				LCNT_OFS: begin
					wd = merge(lcnt_word, i_avs_writedata, i_avs_byteenable);
					if (i_avs_byteenable[0]) begin
						next_pulse_level = wd[LEVEL_POS];
					end
					if (i_avs_byteenable[COUNT_POS/8]) begin
						// a load restarts the count, zero leaves it stopped
						next_pulse_length_count = wd[COUNT_POS +: 8];
						next_count_run = wd[COUNT_POS +: 8] != 8'h00;
					end
				end
				STAT_OFS: begin
					if (i_avs_byteenable[0]) begin
						next_flags = flags & ~i_avs_writedata[2:0];
					end
				end
				MASK_OFS: begin
					if (i_avs_byteenable[0]) begin
						next_mask = i_avs_writedata[2:0];
					end
				end
				default: begin
					wd = 32'h0000_0000;  // unmapped writes are dropped
				end
			endcase
		end
		// a new event wins over a clear in the same cycle
		next_flags[UNDER_POS] = next_flags[UNDER_POS] | under_evt;
		next_flags[RISE_POS] = next_flags[RISE_POS] | rise_evt;
		next_flags[FALL_POS] = next_flags[FALL_POS] | fall_evt;
		next_irq = |(next_flags & next_mask);

		// modulator: carrier-gated level, low while disabled or receiving
		next_tx = next_unit_enable && unit_enable && !direction_select && pulse_level
			&& car_phase;
	end

	////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			unit_enable <= 1'b0;
			direction_select <= 1'b0;
			carrier_clock_divsel <= DIV_RST;
			length_clock_divsel <= DIV_RST;
			carrier_high_len <= LEN_RST;
			carrier_low_len <= LEN_RST;
			pulse_level <= 1'b0;
			pulse_length_count <= COUNT_RST;
			count_run <= 1'b0;
			flags <= FLAG_RST;
			mask <= FLAG_RST;
			pre <= '0;
			car_phase <= 1'b1;
			car_cnt <= '0;
			rx_sample <= 1'b0;
			rx_level <= 1'b0;
			o_avs_readdata <= 32'h0000_0000;
			o_avs_waitrequest <= 1'b1;
			o_ir_tx_output <= 1'b0;
			o_irq <= 1'b0;
		end else begin
			unit_enable <= next_unit_enable;
			direction_select <= next_direction_select;
			carrier_clock_divsel <= next_carrier_clock_divsel;
			length_clock_divsel <= next_length_clock_divsel;
			carrier_high_len <= next_carrier_high_len;
			carrier_low_len <= next_carrier_low_len;
			pulse_level <= next_pulse_level;
			pulse_length_count <= next_pulse_length_count;
			count_run <= next_count_run;
			flags <= next_flags;
			mask <= next_mask;
			pre <= next_pre;
			car_phase <= next_car_phase;
			car_cnt <= next_car_cnt;
			rx_sample <= next_rx_sample;
			rx_level <= next_rx_level;
			o_avs_readdata <= next_readdata;
			o_avs_waitrequest <= next_waitrequest;
			o_ir_tx_output <= next_tx;
			o_irq <= next_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	sequence bus_req_s;
		(i_avs_read || i_avs_write) && o_avs_waitrequest;
	endsequence
	sequence bus_ans_s;
		!o_avs_waitrequest;
	endsequence
	sequence last_count_s;
		unit_enable && count_run && lc_tick && pulse_length_count == 8'h01;
	endsequence

	bus_answer_a: assert property (bus_req_s |=> bus_ans_s)
		else $error("bus request not answered in one cycle");
	tx_off_low_a: assert property (!unit_enable |=> !o_ir_tx_output)
		else $error("transmit pin high while disabled");
	tx_level_zero_a: assert property (!pulse_level |=> !o_ir_tx_output)
		else $error("transmit pin high with level zero");
	carrier_start_a: assert property (!unit_enable |=> car_phase && car_cnt == 6'h00)
		else $error("carrier not reset to high section");
	div_full_a: assert property (unit_enable && carrier_clock_divsel == 4'h0 |-> cg_tick)
		else $error("undivided carrier clock missed a tick");
	div_reserved_a: assert property (length_clock_divsel == DIV_RESERVED |-> !lc_tick)
		else $error("reserved code produced a tick");
	under_flag_a: assert property (last_count_s |=> flags[UNDER_POS] && !count_run
		&& pulse_length_count == 8'h00)
		else $error("underflow did not flag and stop");
	count_hold_a: assert property (!count_run && !wr_go |=> $stable(pulse_length_count))
		else $error("stopped counter moved");
	edge_glitch_a: assert property (rise_evt || fall_evt |-> rx_sample == rx_sync
		&& direction_select)
		else $error("edge accepted without two equal samples");
	irq_level_a: assert property (o_irq == |(flags & mask))
		else $error("interrupt output disagrees with flags");

endmodule  // ir_remote_unit

// ==== ir_far_model.sv ====
// far side: emitter driving the receive pin, receiver counting transmit activity
// assumes the bench calls emit right after a rising clock edge
module ir_far_model (
	// clock
	input  wire logic i_clk,
	// transmit pin as seen by the receiver
	input  wire logic i_tx,
	// receive pin driven by the emitter
	output logic      o_rx
);
	timeunit 1ns;
	timeprecision 1ns;
	int   highs; // transmit samples seen high
	int   rises; // transmit rising edges seen
	logic prev;  // previous transmit sample
	initial begin
		o_rx = 1'b0;
		highs = 0;
		rises = 0;
		prev = 1'b0;
	end
	// receiver: sample the settled pin once per cycle
	always @(negedge i_clk) begin
		if (i_tx === 1'b1) highs++;
		if (i_tx === 1'b1 && prev !== 1'b1) rises++;
		prev = i_tx;
	end
	// emitter: hold a level n cycles; a one-cycle level is noise
	task automatic emit(input logic lvl, input int n);
		o_rx <= lvl;
		repeat (n) @(posedge i_clk);
	endtask
endmodule // ir_far_model

// ==== tb_top.sv ====
// self-checking bench for the infrared remote unit
// assumes the far-side model file is compiled first
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import ir_remote_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0]  avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        rx;
	logic        tx;
	logic        irq;
	logic [31:0] q;     // last read data
	int          error_cnt = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	int          n;
	always #25 ref_clk = ~ref_clk;
	ir_remote_unit ir_remote_unit_inst (.i_ref_clk(ref_clk), .i_rst(rst),
		.i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
		.i_avs_writedata(avs_writedata), .i_avs_byteenable(avs_byteenable),
		.o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
		.i_ir_rx_input(rx), .o_ir_tx_output(tx), .o_irq(irq));
	ir_far_model ir_far_model_inst (.i_clk(ref_clk), .i_tx(tx), .o_rx(rx));
	// watchdog against a hung handshake
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one avalon access: raised after a rising edge, held until waitrequest is
	// sampled low at a rising edge, released at that same edge
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_read <= ~w;
		avs_write <= w;
		avs_writedata <= d;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	// settings change only while disabled, then enable
	task automatic run(input logic dir, input logic [3:0] cd, input logic [3:0] ld);
		bus(1'b1, CFG_OFS, {20'h0_0000, ld, cd, 2'b00, dir, 1'b0});
		@(posedge ref_clk);
		check(32'(tx), 32'h0000_0000);
		bus(1'b1, CFG_OFS, {20'h0_0000, ld, cd, 2'b00, dir, 1'b1});
	endtask
	task automatic window(input int len, input int hi, input int ri);
		repeat (30) @(posedge ref_clk);
		ir_far_model_inst.highs = 0;
		ir_far_model_inst.rises = 0;
		repeat (len) @(posedge ref_clk);
		check(32'(ir_far_model_inst.highs), 32'(hi));
		check(32'(ir_far_model_inst.rises), 32'(ri));
	endtask
	task automatic wait_irq();
		n = 0;
		while (irq !== 1'b1 && n < 400) begin
			@(posedge ref_clk);
			n++;
		end
	endtask
	task automatic t_reset();
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, 5'(i * 4), 32'h0000_0000);
			check(q, 32'h0000_0000);
		end
		// a single-lane write keeps the other lane's field
		avs_byteenable <= 4'h1;
		bus(1'b1, CAR_OFS, 32'h0000_3f3f);
		avs_byteenable <= 4'hf;
		bus(1'b0, CAR_OFS, 32'h0000_0000);
		check(q, 32'h0000_003f);
		check(32'({tx, irq}), 32'h0000_0000);
		$display("reset test done");
	endtask
	task automatic t_carrier();
		bus(1'b1, LCNT_OFS, 32'h0000_0001);
		bus(1'b1, CAR_OFS, 32'h0000_0001);
		for (int c = 0; c < 4; c++) begin
			run(1'b0, 4'(c), 4'h0);
			window(48, 32, 16 >> c);
		end
		bus(1'b1, CAR_OFS, 32'h0000_0102);
		run(1'b0, 4'h0, 4'h0);
		repeat (2) @(posedge ref_clk);
		check(32'(tx), 32'h0000_0001);
		repeat (3) @(posedge ref_clk);
		check(32'(tx), 32'h0000_0000);
		window(40, 24, 8);
		bus(1'b1, LCNT_OFS, 32'h0000_0000);
		window(20, 0, 0);
		bus(1'b1, LCNT_OFS, 32'h0000_0001);
		run(1'b1, 4'h0, 4'h0);
		window(20, 0, 0);
		$display("carrier test done");
	endtask
	task automatic t_counter();
		bus(1'b1, MASK_OFS, 32'h0000_0001);
		for (int l = 1; l < 4; l += 2) begin
			run(1'b0, 4'h0, 4'(l));
			bus(1'b1, LCNT_OFS, 32'h0000_0400);
			wait_irq();
			check(32'(n >= (3 << l) && n <= (4 << l) + 3), 32'h0000_0001);
			repeat (20) @(posedge ref_clk);
			bus(1'b0, LCNT_OFS, 32'h0000_0000);
			check(32'(q[15:8]), 32'h0000_0000);
			bus(1'b0, STAT_OFS, 32'h0000_0000);
			check(q, 32'h0000_0001);
			bus(1'b1, STAT_OFS, 32'h0000_0001);
			bus(1'b0, STAT_OFS, 32'h0000_0000);
			check(32'({q[2:0], irq}), 32'h0000_0000);
		end
		bus(1'b1, MASK_OFS, 32'h0000_0000);
		bus(1'b1, LCNT_OFS, 32'h0000_0100);
		repeat (20) @(posedge ref_clk);
		bus(1'b0, STAT_OFS, 32'h0000_0000);
		check(32'({q[2:0], irq}), 32'h0000_0002);
		bus(1'b1, STAT_OFS, 32'h0000_0001);
		run(1'b0, 4'h0, 4'hf);
		bus(1'b1, LCNT_OFS, 32'h0000_0200);
		repeat (100) @(posedge ref_clk);
		bus(1'b0, LCNT_OFS, 32'h0000_0000);
		check(32'(q[15:8]), 32'h0000_0002);
		// a zero load stops the counter so the next enable starts clean
		bus(1'b1, LCNT_OFS, 32'h0000_0000);
		bus(1'b0, STAT_OFS, 32'h0000_0000);
		check(q, 32'h0000_0000);
		$display("counter test done");
	endtask
	task automatic t_receive();
		bus(1'b1, MASK_OFS, 32'h0000_0006);
		run(1'b1, 4'h0, 4'h0);
		ir_far_model_inst.emit(1'b1, 1);
		ir_far_model_inst.emit(1'b0, 12);
		bus(1'b0, STAT_OFS, 32'h0000_0000);
		check(q, 32'h0000_0000);
		ir_far_model_inst.emit(1'b1, 12);
		bus(1'b0, STAT_OFS, 32'h0000_0000);
		check(32'({q[2:0], irq}), 32'h0000_0005);
		bus(1'b1, STAT_OFS, 32'h0000_0002);
		bus(1'b1, LCNT_OFS, 32'h0000_ff00);
		ir_far_model_inst.emit(1'b1, 40);
		ir_far_model_inst.emit(1'b0, 0);
		wait_irq();
		bus(1'b0, LCNT_OFS, 32'h0000_0000);
		n = 255 - int'(q[15:8]);
		check(32'(n >= 40 && n <= 52), 32'h0000_0001);
		bus(1'b0, STAT_OFS, 32'h0000_0000);
		check(q, 32'h0000_0004);
		bus(1'b1, STAT_OFS, 32'h0000_0004);
		run(1'b1, 4'h0, 4'h0);
		$display("receive test done");
	endtask
	// reset, then the scenarios in turn
	initial begin
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		t_reset();
		t_carrier();
		t_counter();
		t_receive();
		finish_test();
	end
endmodule // tb_top
